// ==== include/wwd_pkg.sv ====
// constants, types and register map of the window watchdog with arm gating
package wwd_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int RST_PULSE_NS   = 1_000_000;   // 1.0 ms
  localparam int POR_DELAY_NS   = 1_000_000;
  localparam int WIN_MIN_NS     = 2_000_000;
  localparam int WIN_MAX_NS     = 20_000_000;
  // least times round up, longest times round down
  localparam int RST_PULSE_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_DELAY_CYC  = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_MIN_CYC    = (WIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_MAX_CYC    = WIN_MAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 24;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int ADDR_W         = 4;
  localparam int DATA_W         = 32;
  localparam logic [ADDR_W-1:0] ADDR_CMD    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_ARM    = 4'h8;

  // command register fields (write only, read as zero)
  localparam int CMD_POL_BIT    = 0;
  localparam int CMD_FEED_BIT   = 1;
  localparam int CMD_TEST_BIT   = 2;
  localparam int CMD_OVR_BIT    = 3;

  // status register fields
  localparam int STS_ERR_BIT    = 0;
  localparam int STS_LOCK_BIT   = 1;
  localparam int STS_STATE_LSB  = 2;
  localparam int STS_RST_BIT    = 4;
  localparam int STS_POR_BIT    = 5;
  localparam int STS_POL_BIT    = 6;

  // arm level register fields and reset value
  localparam int ARM_LVL_BIT    = 0;
  localparam int ARM_CPL_BIT    = 1;
  localparam logic ARM_LVL_RST  = 1'b0;
  localparam logic ARM_CPL_RST  = 1'b1;

  // ---------------------------------------------------------------
  // service state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    WWD_INIT,
    WWD_DRIVE,
    WWD_TEST,
    WWD_OVERRIDE
  } wwd_state_e;

endpackage : wwd_pkg

// ==== src/wwd_top.sv ====
// window watchdog, system reset merge and arm output gating
`timescale 1ns/1ps

module wwd_top
  import wwd_pkg::*;
#(
  parameter int WIN_MIN_CYCLES   = wwd_pkg::WIN_MIN_CYC,
  parameter int WIN_MAX_CYCLES   = wwd_pkg::WIN_MAX_CYC,
  parameter int RST_PULSE_CYCLES = wwd_pkg::RST_PULSE_CYC,
  parameter int POR_DELAY_CYCLES = wwd_pkg::POR_DELAY_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [wwd_pkg::ADDR_W-1:0] addr,
  input  wire logic [wwd_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [wwd_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       main_supply_ok,
  input  wire logic                       logic_supply_ok,
  input  wire logic                       ground_ok,
  input  wire logic                       reference_ok,
  input  wire logic                       service_machine_reset,
  input  wire logic                       safing_machine_reset,
  input  wire logic                       sleep_logic_reset,
  input  wire logic                       analog_failsafe_reset,
  output logic                            reset_out_n,
  output logic                            core_reset,
  output logic                            safing_reset_out,
  output logic                            sleep_reset_out,
  output logic                            watchdog_error_flag,
  output logic                            arm_o,
  output logic                            arm_oe,
  output logic                            arm_enable_complement_o,
  output logic                            arm_enable_complement_oe
);
  import wwd_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    wwd_state_e        state;
    logic              prev_pol;
    logic [CNT_W-1:0]  win_cnt;
    logic [CNT_W-1:0]  pulse_cnt;
    logic [CNT_W-1:0]  por_cnt;
    logic              por_done;
    logic              err_flag;
    logic              lockout;
    logic              bypass_hold;
    logic              arm_lvl;
    logic              cpl_lvl;
    logic [DATA_W-1:0] rd_data;
    logic              rst_n;
    logic              core_rst;
    logic              ssm_rst;
    logic              slp_rst;
    logic              arm_o;
    logic              cpl_o;
    logic              oe;
  } wwd_state_s;

  wwd_state_s state_reg;
  wwd_state_s state_next;

  localparam logic [CNT_W-1:0] MIN_C   = CNT_W'(WIN_MIN_CYCLES);
  localparam logic [CNT_W-1:0] MAX_C   = CNT_W'(WIN_MAX_CYCLES);
  localparam logic [CNT_W-1:0] PULSE_C = CNT_W'(RST_PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] POR_C   = CNT_W'(POR_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic feed;
  logic feed_pol;
  logic test_cmd;
  logic ovr_cmd;
  logic sys_ok;
  logic sys_rst;
  logic win_ok;
  logic timeout;
  logic err;
  logic good;
  logic bypass;
  logic in_drive;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rd_data = '0;
    feed     = wr_en && (addr == ADDR_CMD) && wr_data[CMD_FEED_BIT];
    feed_pol = wr_data[CMD_POL_BIT];
    test_cmd = wr_en && (addr == ADDR_CMD) && wr_data[CMD_TEST_BIT];
    ovr_cmd  = wr_en && (addr == ADDR_CMD) && wr_data[CMD_OVR_BIT];
    err  = 1'b0;
    good = 1'b0;

    // monitor merge; supplies are taken as already synchronous
    sys_ok = main_supply_ok && logic_supply_ok && ground_ok && reference_ok;
    sys_rst = !sys_ok || !state_reg.por_done || (state_reg.pulse_cnt != '0);
    state_next.core_rst = !logic_supply_ok || !reference_ok;
    state_next.ssm_rst  = safing_machine_reset;
    state_next.slp_rst  = sleep_logic_reset;

    // power-on delay restarts whenever the main supply drops
    if (!main_supply_ok) begin
      state_next.por_cnt  = '0;
      state_next.por_done = 1'b0;
    end else if (!state_reg.por_done) begin
      if (state_reg.por_cnt == POR_C) begin
        state_next.por_done = 1'b1;
      end else begin
        state_next.por_cnt = state_reg.por_cnt + CNT_ONE;
      end
    end

    // window check; a feed exactly at the limit still counts
    win_ok  = (state_reg.win_cnt >= MIN_C) && (state_reg.win_cnt <= MAX_C);
    timeout = (state_reg.win_cnt >= MAX_C) && !feed;

    case (state_reg.state)
      WWD_INIT: begin
        state_next.win_cnt = '0;
        if (state_reg.por_done && ovr_cmd) begin
          state_next.state = WWD_OVERRIDE;
        end else if (state_reg.por_done && feed) begin
          state_next.state    = WWD_DRIVE;
          state_next.prev_pol = feed_pol;
          good = 1'b1;
        end
      end
      WWD_DRIVE, WWD_TEST: begin
        if (feed) begin
          state_next.win_cnt  = '0;
          state_next.prev_pol = feed_pol;
          if ((feed_pol != state_reg.prev_pol) && win_ok) begin
            good = 1'b1;
          end else begin
            err = 1'b1;
          end
        end else if (timeout) begin
          state_next.win_cnt = '0;
          err = 1'b1;
        end else begin
          state_next.win_cnt = state_reg.win_cnt + CNT_ONE;
        end
        // the test mark only lives until the current window closes
        if (feed || timeout) begin
          state_next.state = WWD_DRIVE;
        end else if (test_cmd) begin
          state_next.state = WWD_TEST;
        end
      end
      WWD_OVERRIDE: begin
        // timing stops; polarity still tracked for later reads
        state_next.win_cnt = '0;
        if (feed) begin
          state_next.prev_pol = feed_pol;
        end
      end
      default: begin
        state_next.state = WWD_INIT;
      end
    endcase

    // failure: pulse, flag, and lockout only when erring from plain drive
    if (err) begin
      state_next.err_flag  = 1'b1;
      state_next.pulse_cnt = PULSE_C;
      if (state_reg.state == WWD_TEST) begin
        state_next.bypass_hold = 1'b1;
      end else begin
        state_next.lockout = 1'b1;
      end
    end else begin
      if (good) begin
        state_next.err_flag = 1'b0;
      end
      if (state_reg.pulse_cnt != '0) begin
        state_next.pulse_cnt = state_reg.pulse_cnt - CNT_ONE;
        if (state_reg.pulse_cnt == CNT_ONE) begin
          state_next.bypass_hold = 1'b0;
        end
      end
    end

    // a system reset seen in plain drive locks the arm outputs, except while bypass_hold is set
    if (sys_rst && (state_reg.state == WWD_DRIVE) && !state_reg.bypass_hold) begin
      state_next.lockout = 1'b1;
    end

    // reset pin; the error term makes the pulse start without a lag
    state_next.rst_n = sys_ok && state_reg.por_done
                       && (state_reg.pulse_cnt == '0) && !err;

    // machine reset wins over a coincident error's flag and lockout on the same edge; the reset pulse still starts
    if (service_machine_reset) begin
      state_next.state       = WWD_INIT;
      state_next.win_cnt     = '0;
      state_next.err_flag    = 1'b0;
      state_next.lockout     = 1'b0;
      state_next.bypass_hold = 1'b0;
    end

    // supply ramp keeps the machine parked and the flag clear
    if (!state_reg.por_done) begin
      state_next.state       = WWD_INIT;
      state_next.err_flag    = 1'b0;
      state_next.lockout     = 1'b0;
      state_next.bypass_hold = 1'b0;
      state_next.win_cnt     = '0;
    end

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    if (state_reg.core_rst) begin
      state_next.arm_lvl = ARM_LVL_RST;
      state_next.cpl_lvl = ARM_CPL_RST;
    end else if (wr_en && (addr == ADDR_ARM)) begin
      state_next.arm_lvl = wr_data[ARM_LVL_BIT];
      state_next.cpl_lvl = wr_data[ARM_CPL_BIT];
    end
    if (rd_en) begin
      case (addr)
        ADDR_STATUS: begin
          state_next.rd_data[STS_ERR_BIT] = state_reg.err_flag;
          state_next.rd_data[STS_LOCK_BIT] = state_reg.lockout;
          state_next.rd_data[STS_STATE_LSB +: 2] = state_reg.state;
          state_next.rd_data[STS_RST_BIT] = !state_reg.rst_n;
          state_next.rd_data[STS_POR_BIT] = state_reg.por_done;
          state_next.rd_data[STS_POL_BIT] = state_reg.prev_pol;
        end
        ADDR_ARM: begin
          state_next.rd_data[ARM_LVL_BIT] = state_reg.arm_lvl;
          state_next.rd_data[ARM_CPL_BIT] = state_reg.cpl_lvl;
        end
        default: begin
          state_next.rd_data = '0;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // arm gating
    // ---------------------------------------------------------------
    in_drive = (state_reg.state == WWD_DRIVE) || (state_reg.state == WWD_TEST);
    bypass   = (state_reg.state != WWD_DRIVE) || state_reg.bypass_hold;
    state_next.oe = !analog_failsafe_reset
                    && (!sys_rst || bypass)
                    && ((state_reg.state == WWD_OVERRIDE)
                        || (in_drive && !safing_machine_reset
                            && !state_reg.lockout));
    state_next.arm_o = state_reg.arm_lvl;
    // equal levels allowed in init, test and override; plain drive keeps the pair complementary
    if (state_reg.state == WWD_DRIVE) begin
      state_next.cpl_o = !state_reg.arm_lvl;
    end else begin
      state_next.cpl_o = state_reg.cpl_lvl;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg             <= '0;
      state_reg.state       <= WWD_INIT;
      state_reg.core_rst    <= 1'b1;
      state_reg.ssm_rst     <= 1'b1;
      state_reg.slp_rst     <= 1'b1;
      state_reg.arm_lvl     <= ARM_LVL_RST;
      state_reg.cpl_lvl     <= ARM_CPL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data                  = state_reg.rd_data;
  assign reset_out_n              = state_reg.rst_n;
  assign core_reset               = state_reg.core_rst;
  assign safing_reset_out         = state_reg.ssm_rst;
  assign sleep_reset_out          = state_reg.slp_rst;
  assign watchdog_error_flag      = state_reg.err_flag;
  assign arm_o                    = state_reg.arm_o;
  assign arm_oe                   = state_reg.oe;
  assign arm_enable_complement_o  = state_reg.cpl_o;
  assign arm_enable_complement_oe = state_reg.oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  reset_merge_a: assert property (
    !(main_supply_ok && logic_supply_ok && ground_ok && reference_ok) |=> !reset_out_n)
    else $error("monitor fault did not pull reset low");

  ramp_hold_a: assert property (
    !main_supply_ok |=> !reset_out_n ##1 (!watchdog_error_flag && state_reg.state == WWD_INIT))
    else $error("supply ramp did not hold reset and clear the machine");

  init_idle_a: assert property (
    (state_reg.state == WWD_INIT) |-> (state_reg.win_cnt == '0))
    else $error("window timing runs before first service");

  init_hiz_a: assert property (
    (state_reg.state == WWD_INIT && $past(state_reg.state) == WWD_INIT) |-> !arm_oe)
    else $error("arm outputs driven before first service");

  first_feed_a: assert property (
    (state_reg.state == WWD_INIT && state_reg.por_done && feed && !ovr_cmd
     && !service_machine_reset && main_supply_ok) |=> (state_reg.state == WWD_DRIVE))
    else $error("first service did not enter drive");

  same_pol_a: assert property (
    (in_drive && feed && feed_pol == state_reg.prev_pol && state_reg.por_done
     && !service_machine_reset) |=> (watchdog_error_flag && !reset_out_n))
    else $error("repeated polarity not flagged");

  pulse_len_a: assert property (
    err && !service_machine_reset && main_supply_ok |=> !reset_out_n [*8])
    else $error("watchdog reset pulse too short");

  pulse_cnt_a: assert property (
    err |=> (state_reg.pulse_cnt == PULSE_C))
    else $error("reset pulse counter not loaded");

  good_clear_a: assert property (
    (good && state_reg.por_done && !service_machine_reset) |=> !watchdog_error_flag)
    else $error("good service did not clear error flag");

  test_nolock_a: assert property (
    (err && state_reg.state == WWD_TEST && !state_reg.lockout && !service_machine_reset)
    |=> !state_reg.lockout [*2])
    else $error("error from test state caused lockout");

  drive_lock_a: assert property (
    (err && state_reg.state == WWD_DRIVE && state_reg.por_done && !service_machine_reset)
    |=> state_reg.lockout)
    else $error("error from drive state left lockout clear");

  wsm_clear_a: assert property (
    service_machine_reset |=> (state_reg.state == WWD_INIT && !state_reg.lockout
                              && !watchdog_error_flag))
    else $error("machine reset did not clear state");

  failsafe_hiz_a: assert property (
    analog_failsafe_reset |=> (!arm_oe && !arm_enable_complement_oe))
    else $error("failsafe reset left arm outputs driven");

  gate_lock_a: assert property (
    (state_reg.lockout && state_reg.state != WWD_OVERRIDE) |=> !arm_oe)
    else $error("arm outputs driven under lockout");

endmodule : wwd_top

// ==== tb/wwd_host_model.sv ====
// host model that speaks the register port of the watchdog block
`timescale 1ns/1ps

module wwd_host_model
  import wwd_pkg::*;
(
  input  wire logic                       clk,
  output logic      [wwd_pkg::ADDR_W-1:0] addr,
  output logic      [wwd_pkg::DATA_W-1:0] wr_data,
  output logic                            wr_en,
  output logic                            rd_en,
  input  wire logic [wwd_pkg::DATA_W-1:0] rd_data
);
  logic last_pol;

  initial begin
    addr     = '0;
    wr_data  = '0;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    last_pol = 1'b0;
  end

  // ---------------------------------------------------------------
  // bus cycles and commands
  // ---------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
    wr_data <= ~d;  // released data must not linger as a valid word
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // polarity flips on every call so a caller cannot repeat one by accident
  task automatic feed();
    last_pol = ~last_pol;
    wr(ADDR_CMD, {30'h0, 1'h1, last_pol});
  endtask : feed

  // deliberate fault: same polarity as the service before
  task automatic feed_same();
    wr(ADDR_CMD, {30'h0, 1'h1, last_pol});
  endtask : feed_same

  task automatic bypass();
    wr(ADDR_CMD, 32'h1 << CMD_TEST_BIT);
  endtask : bypass

  task automatic override();
    wr(ADDR_CMD, 32'h1 << CMD_OVR_BIT);
  endtask : override
endmodule : wwd_host_model

// ==== tb/window_watchdog_arm_gate_bench.sv ====
// self-checking bench for the window watchdog with arm gating
`timescale 1ns/1ps

module window_watchdog_arm_gate_bench;
  import wwd_pkg::*;
  // ---------------------------------------------------------------
  // short counts so a window lasts tens of cycles
  // ---------------------------------------------------------------
  localparam int WMIN  = 10;
  localparam int WMAX  = 40;
  localparam int PULSE = 12;
  localparam int POR   = 5;
  localparam int LIMIT = 5000;

  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] st;
  logic              wr_en;
  logic              rd_en;
  logic [3:0]        mon_ok;
  logic              smr, safr, slpr, afr;
  logic              rst_n_o, core_o, saf_o, slp_o, flag;
  logic              arm_o, arm_oe, cpl_o, cpl_oe;
  int                errors;
  int                n_compared;
  int                cycles;

  wwd_top #(.WIN_MIN_CYCLES(WMIN), .WIN_MAX_CYCLES(WMAX),
    .RST_PULSE_CYCLES(PULSE), .POR_DELAY_CYCLES(POR)) dut_u (
    .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .main_supply_ok(mon_ok[0]),
    .logic_supply_ok(mon_ok[1]), .ground_ok(mon_ok[2]), .reference_ok(mon_ok[3]),
    .service_machine_reset(smr), .safing_machine_reset(safr),
    .sleep_logic_reset(slpr), .analog_failsafe_reset(afr), .reset_out_n(rst_n_o),
    .core_reset(core_o), .safing_reset_out(saf_o), .sleep_reset_out(slp_o),
    .watchdog_error_flag(flag), .arm_o(arm_o), .arm_oe(arm_oe),
    .arm_enable_complement_o(cpl_o), .arm_enable_complement_oe(cpl_oe));

  wwd_host_model host_u (.clk(clk), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // a hang is cut short here and counted as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", w, e, g);
      errors++;
    end
  endtask : chk

  // the extra 1 ns lets the edge's updates land before any look
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic mreset();
    @(posedge clk) smr <= 1'b1;
    step(2);
    @(posedge clk) smr <= 1'b0;
    step(2);
  endtask : mreset

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_start();
    chk("reset pin", 1'h0, rst_n_o);
    chk("error flag", 1'h0, flag);
    @(posedge clk) nrst <= 1'b1;
    step(POR - 1);
    chk("reset pin", 1'h0, rst_n_o);
    step(5);
    chk("reset pin", 1'h1, rst_n_o);
    step(WMAX + 5);
    host_u.rd(ADDR_STATUS, st);
    chk("status", 32'h20, st & 32'h3F);
    chk("arm enable", 1'h0, arm_oe);
    chk("complement enable", 1'h0, cpl_oe);
    host_u.rd(ADDR_ARM, st);
    chk("arm reg", 32'h2, st);
    host_u.rd(4'hC, st);
    chk("unmapped", 32'h0, st);
    $display("start test done");
  endtask : t_start

  task automatic t_feed();
    host_u.feed();
    host_u.rd(ADDR_STATUS, st);
    chk("state", WWD_DRIVE, st[3:2]);
    chk("arm enable", 1'h1, arm_oe);
    chk("complement enable", 1'h1, cpl_oe);
    host_u.wr(ADDR_ARM, 32'h1);
    step(2);
    chk("arm level", 1'h1, arm_o);
    chk("complement level", 1'h0, cpl_o);
    step(WMIN);
    host_u.feed();
    step(2);
    chk("error flag", 1'h0, flag);
    chk("reset pin", 1'h1, rst_n_o);
    @(posedge clk) safr <= 1'b1;
    step(2);
    chk("arm enable", 1'h0, arm_oe);
    chk("safing out", 1'h1, saf_o);
    @(posedge clk) afr <= 1'b1;
    @(posedge clk) safr <= 1'b0;
    step(2);
    chk("arm enable", 1'h0, arm_oe);
    @(posedge clk) afr <= 1'b0;
    step(2);
    chk("arm enable", 1'h1, arm_oe);
    mreset();
    $display("feed test done");
  endtask : t_feed

  task automatic t_repeat();
    host_u.feed();
    step(WMIN + 2);
    host_u.feed_same();
    step(2);
    chk("error flag", 1'h1, flag);
    chk("reset pin", 1'h0, rst_n_o);
    chk("arm enable", 1'h0, arm_oe);
    step(PULSE - 3);
    chk("reset pin", 1'h0, rst_n_o);
    step(1);
    chk("reset pin", 1'h1, rst_n_o);
    host_u.rd(ADDR_STATUS, st);
    chk("status", 32'h07, st & 32'h1F);
    chk("arm enable", 1'h0, arm_oe);
    host_u.feed();
    step(2);
    chk("error flag", 1'h0, flag);
    chk("arm enable", 1'h0, arm_oe);
    mreset();
    host_u.rd(ADDR_STATUS, st);
    chk("status", 32'h20, st & 32'h3F);
    $display("repeat test done");
  endtask : t_repeat

  task automatic t_early_late();
    host_u.feed();
    step(2);
    host_u.feed();
    step(2);
    chk("error flag", 1'h1, flag);
    mreset();
    chk("error flag", 1'h0, flag);
    host_u.feed();
    step(WMAX + 4);
    chk("error flag", 1'h1, flag);
    mreset();
    step(PULSE);
    $display("window test done");
  endtask : t_early_late

  task automatic t_bypass();
    host_u.feed();
    step(2);
    host_u.bypass();
    host_u.rd(ADDR_STATUS, st);
    chk("state", WWD_TEST, st[3:2]);
    host_u.feed_same();
    step(2);
    chk("error flag", 1'h1, flag);
    chk("reset pin", 1'h0, rst_n_o);
    chk("arm enable", 1'h1, arm_oe);
    step(PULSE);
    host_u.rd(ADDR_STATUS, st);
    chk("lockout", 1'h0, st[STS_LOCK_BIT]);
    mreset();
    $display("bypass test done");
  endtask : t_bypass

  task automatic t_override();
    host_u.override();
    host_u.rd(ADDR_STATUS, st);
    chk("state", WWD_OVERRIDE, st[3:2]);
    host_u.wr(ADDR_ARM, 32'h3);
    step(2);
    chk("arm enable", 1'h1, arm_oe);
    chk("arm level", 1'h1, arm_o);
    chk("complement level", 1'h1, cpl_o);
    host_u.feed();
    host_u.feed_same();
    step(2);
    chk("error flag", 1'h0, flag);
    chk("reset pin", 1'h1, rst_n_o);
    mreset();
    host_u.rd(ADDR_STATUS, st);
    chk("state", WWD_INIT, st[3:2]);
    $display("override test done");
  endtask : t_override

  task automatic t_sources();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) mon_ok <= 4'hF & ~(4'h1 << i);
      step(2);
      chk("reset pin", 1'h0, rst_n_o);
      chk("core reset", (i == 1 || i == 3), core_o);
      @(posedge clk) mon_ok <= 4'hF;
      step(POR + 4);
      chk("reset pin", 1'h1, rst_n_o);
    end
    @(posedge clk) slpr <= 1'b1;
    step(2);
    chk("sleep out", 1'h1, slp_o);
    chk("error flag", 1'h0, flag);
    $display("source test done");
  endtask : t_sources

  initial begin
    nrst = 1'b0;
    mon_ok = 4'hF;
    {smr, safr, slpr, afr} = 4'h0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    step(5);
    t_start();
    t_feed();
    t_repeat();
    t_early_late();
    t_bypass();
    t_override();
    t_sources();
    print_verdict();
  end
endmodule : window_watchdog_arm_gate_bench
